// file: pla_pkg.sv
// Purpose: shared constants and types of the programmable logic section
// Assumes: 16-bit host data, one 10 MHz clock
// Notes: input bus layout, register map, reset values, timing counts
`default_nettype none
package pla_pkg;

  // shared input bus layout
  localparam int IN_BUS_W = 82;
  localparam int BUS_ADDR_LSB = 0;
  localparam int BUS_CTL_LSB = 16;
  localparam int BUS_RST = 19;
  localparam int BUS_PDN = 20;
  localparam int BUS_PA_LSB = 21;
  localparam int BUS_PB_LSB = 29;
  localparam int BUS_PC_LSB = 37;
  localparam int BUS_PD_LSB = 45;
  localparam int BUS_PF_LSB = 49;
  localparam int BUS_PAGE_LSB = 57;
  localparam int BUS_FBA_LSB = 65;
  localparam int BUS_FBB_LSB = 73;
  localparam int BUS_RDY = 81;

  // array sizes
  localparam int GEN_PT_NUM = 196;
  localparam int DEC_PT_NUM = 43;
  localparam int CELL_NUM = 16;
  localparam int SLOT_NUM = 10;
  localparam int PT_IDX_W = 8;
  localparam int ECS_NUM = 8;

  // decode array product term layout
  localparam int DEC_TERMS = 3;
  localparam int DEC_MAIN_LSB = 0;
  localparam int DEC_BOOT_LSB = 24;
  localparam int DEC_SRAM_LSB = 36;
  localparam int DEC_CFG = 39;
  localparam int DEC_JTAG = 40;
  localparam int DEC_PERIPH_LSB = 41;

  // product terms per cell
  localparam int A_NATIVE = 3;
  localparam int A_BORROW = 6;
  localparam int B_LO_NATIVE = 4;
  localparam int B_LO_BORROW = 5;
  localparam int B_HI_NATIVE = 4;
  localparam int B_HI_BORROW = 6;

  // register map (word index on the host port)
  localparam logic [3:0] REG_CELLS = 4'h0;
  localparam logic [3:0] REG_MASK_A = 4'h1;
  localparam logic [3:0] REG_MASK_B = 4'h2;
  localparam logic [3:0] REG_IN_AB = 4'h3;
  localparam logic [3:0] REG_IN_C = 4'h4;
  localparam logic [3:0] REG_PWR0 = 4'h5;
  localparam logic [3:0] REG_PWR2 = 4'h6;
  localparam logic [3:0] REG_PAGE = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // reset values and fields
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PWR0_RST = 8'h08;
  localparam logic [4:0] PWR2_RST = 5'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam int TURBO_BIT = 3;
  localparam int PWR2_W = 5;

  // standby timing
  localparam int CLK_NS = 100;
  localparam int STANDBY_NS = 70;
  localparam int STANDBY_CYC = (STANDBY_NS / CLK_NS) < 1 ? 1 : (STANDBY_NS / CLK_NS);

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} pla_ff_e;

endpackage : pla_pkg
`default_nettype wire

// file: pla_and_plane.sv
// Purpose: AND plane forming product terms from the shared input bus
// Assumes: masks are static configuration
// Notes: a term with its enable low is forced low
`timescale 1ns/1ps
`default_nettype none
module pla_and_plane #(
  parameter int PT_NUM = 1
) (
  // shared input bus
  input wire logic [pla_pkg::IN_BUS_W-1:0] inBus,
  // configuration
  input wire logic [PT_NUM*pla_pkg::IN_BUS_W-1:0] trueMask,
  input wire logic [PT_NUM*pla_pkg::IN_BUS_W-1:0] compMask,
  input wire logic [PT_NUM-1:0] ptEnable,
  // product terms
  output logic [PT_NUM-1:0] pt
);
  import pla_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PT_NUM; i++) begin : g_pt
      logic [IN_BUS_W-1:0] tm;
      logic [IN_BUS_W-1:0] cm;
      assign tm = trueMask[i*IN_BUS_W +: IN_BUS_W];
      assign cm = compMask[i*IN_BUS_W +: IN_BUS_W];
      assign pt[i] = ptEnable[i] & (&(~tm | inBus)) & (&(~cm | ~inBus));
    end
  endgenerate

endmodule : pla_and_plane
`default_nettype wire

// file: pla_out_cell.sv
// Purpose: one output cell: polarity XOR, storage element, output select
// Assumes: clock event is a one-cycle pulse in the ref_clk domain
// Notes: preset and clear act at the next ref_clk edge, not instantly
`timescale 1ns/1ps
`default_nettype none
module pla_out_cell (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // terms
  input wire logic sumIn,
  input wire logic auxIn,
  input wire logic presetIn,
  input wire logic clearIn,
  input wire logic clkEvent,
  // host load
  input wire logic loadEn,
  input wire logic loadBit,
  // configuration
  input wire pla_pkg::pla_ff_e ffType,
  input wire logic polarity,
  input wire logic regOut,
  // result
  output logic cellOut,
  output logic cellQ
);
  import pla_pkg::*;

  logic q_r;
  logic d;

  assign d = sumIn ^ polarity;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_r <= 1'b0;
    end else if (loadEn) begin
      q_r <= loadBit;
    end else if (presetIn) begin
      q_r <= 1'b1;
    end else if (clearIn) begin
      q_r <= 1'b0;
    end else if (clkEvent) begin
      unique case (ffType)
        FF_D: q_r <= d;
        FF_T: q_r <= q_r ^ d;
        FF_JK: q_r <= (d & ~q_r) | (~auxIn & q_r);
        FF_SR: q_r <= d | (q_r & ~auxIn);
      endcase
    end
  end

  assign cellQ = q_r;
  assign cellOut = regOut ? q_r : d;

endmodule : pla_out_cell
`default_nettype wire

// file: pla_logic_top.sv
// Purpose: decode array and general logic array with output cells
// Assumes: all configuration inputs static; pins synchronous to ref_clk
// Notes: host reaches cells, masks and power bits over a strobe port
`timescale 1ns/1ps
`default_nettype none
module pla_logic_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // input bus sources and logic clock pin
  input wire logic [19:0] addrIn,
  input wire logic [2:0] busCtlIn,
  input wire logic rstPinIn,
  input wire logic powerDownIn,
  input wire logic [7:0] portAIn,
  input wire logic [7:0] portBIn,
  input wire logic [7:0] portCIn,
  input wire logic [3:0] portDIn,
  input wire logic [7:0] portFIn,
  input wire logic flashReadyIn,
  input wire logic logicClockIn,
  // static mode configuration
  input wire logic sepSpaceMode,
  input wire logic bigEndianHost,
  // general array configuration
  input wire logic [pla_pkg::GEN_PT_NUM*pla_pkg::IN_BUS_W-1:0] cfgGenTrue,
  input wire logic [pla_pkg::GEN_PT_NUM*pla_pkg::IN_BUS_W-1:0] cfgGenComp,
  input wire logic [pla_pkg::GEN_PT_NUM-1:0] cfgGenEn,
  // decode array configuration
  input wire logic [pla_pkg::DEC_PT_NUM*pla_pkg::IN_BUS_W-1:0] cfgDecTrue,
  input wire logic [pla_pkg::DEC_PT_NUM*pla_pkg::IN_BUS_W-1:0] cfgDecComp,
  input wire logic [pla_pkg::DEC_PT_NUM-1:0] cfgDecEn,
  // output cell configuration
  input wire logic [pla_pkg::CELL_NUM*pla_pkg::SLOT_NUM*pla_pkg::PT_IDX_W-1:0] cfgSlotSel,
  input wire logic [pla_pkg::CELL_NUM*pla_pkg::SLOT_NUM-1:0] cfgSlotEn,
  input wire logic [pla_pkg::CELL_NUM*pla_pkg::PT_IDX_W-1:0] cfgAuxSel,
  input wire logic [pla_pkg::CELL_NUM*pla_pkg::PT_IDX_W-1:0] cfgPresetSel,
  input wire logic [pla_pkg::CELL_NUM*pla_pkg::PT_IDX_W-1:0] cfgClr0Sel,
  input wire logic [pla_pkg::CELL_NUM*pla_pkg::PT_IDX_W-1:0] cfgClr1Sel,
  input wire logic [pla_pkg::CELL_NUM*pla_pkg::PT_IDX_W-1:0] cfgClkSel,
  input wire logic [pla_pkg::CELL_NUM-1:0] cfgPresetUse,
  input wire logic [pla_pkg::CELL_NUM-1:0] cfgClr0Use,
  input wire logic [pla_pkg::CELL_NUM-1:0] cfgClr1Use,
  input wire logic [pla_pkg::CELL_NUM-1:0] cfgClkFromPin,
  input wire logic [pla_pkg::CELL_NUM-1:0] cfgPolarity,
  input wire logic [pla_pkg::CELL_NUM-1:0] cfgRegOut,
  input wire logic [pla_pkg::CELL_NUM*2-1:0] cfgFfType,
  // external chip select configuration
  input wire logic [pla_pkg::ECS_NUM*pla_pkg::PT_IDX_W-1:0] cfgEcsSel,
  input wire logic [pla_pkg::ECS_NUM-1:0] cfgEcsPol,
  input wire logic [pla_pkg::ECS_NUM-1:0] cfgEcsToPortF,
  // port pins
  output logic [7:0] portAOut,
  output logic [7:0] portBOut,
  output logic [7:0] ecsPortC,
  output logic [7:0] ecsPortF,
  // decode selects
  output logic [7:0] mainSectorSel,
  output logic [3:0] bootSectorSel,
  output logic sramSel,
  output logic configSpaceSel,
  output logic jtagSel,
  output logic [1:0] periphSel,
  // power status
  output logic arrayStandby
);
  import pla_pkg::*;

  // product term pick, out-of-range indices give a dead term
  function automatic logic ptPick(input logic [GEN_PT_NUM-1:0] pts, input logic [PT_IDX_W-1:0] idx);
    logic r;
    r = 1'b0;
    if (int'(idx) < GEN_PT_NUM) begin
      r = pts[idx];
    end
    return r;
  endfunction : ptPick

  // usable terms per cell: native plus borrowed
  function automatic int cellLimit(input int c);
    int r;
    r = A_NATIVE + A_BORROW;
    if (c >= 12) begin
      r = B_HI_NATIVE + B_HI_BORROW;
    end else if (c >= 8) begin
      r = B_LO_NATIVE + B_LO_BORROW;
    end
    return r;
  endfunction : cellLimit

  logic [7:0] maskA_r;
  logic [7:0] maskB_r;
  logic [7:0] pwr0_r;
  logic [PWR2_W-1:0] pwr2_r;
  logic [7:0] page_r;
  logic [7:0] fbA_r;
  logic [7:0] fbB_r;
  logic [15:0] rdata_r;
  logic [IN_BUS_W-1:0] prevBus_r;
  logic [3:0] idleCnt_r;
  logic standby_r;
  logic logicClkPrev_r;
  logic [CELL_NUM-1:0] ptClkPrev_r;
  logic [7:0] mainSel_r;
  logic [3:0] bootSel_r;
  logic sramSel_r;
  logic cfgSel_r;
  logic jtagSel_r;
  logic [1:0] periphSel_r;
  logic [7:0] ecsC_r;
  logic [7:0] ecsF_r;

  logic [IN_BUS_W-1:0] inBus;
  logic [15:0] arrayAddr;
  logic [2:0] ctlGated;
  logic [GEN_PT_NUM-1:0] genPt;
  logic [DEC_PT_NUM-1:0] decPt;
  logic [CELL_NUM-1:0] cellOut;
  logic [CELL_NUM-1:0] cellQ;
  logic [CELL_NUM-1:0] cellPtClk;
  logic [15:0] cellWordOrdered;
  logic [15:0] loadWord;
  logic cellWrite;
  logic logicClkRise;
  logic [ECS_NUM-1:0] ecsVal;

  // input bus assembly
  assign arrayAddr = sepSpaceMode ? addrIn[19:4] : addrIn[15:0];
  assign ctlGated = busCtlIn & ~pwr2_r[2:0];
  assign inBus = {flashReadyIn, fbB_r, fbA_r, page_r, portFIn, portDIn, portCIn, portBIn, portAIn,
                  powerDownIn, rstPinIn, ctlGated, arrayAddr};

  // both arrays share one bus
  pla_and_plane #(.PT_NUM(GEN_PT_NUM)) u_gen_plane (
    .inBus(inBus),
    .trueMask(cfgGenTrue),
    .compMask(cfgGenComp),
    .ptEnable(cfgGenEn),
    .pt(genPt)
  );

  pla_and_plane #(.PT_NUM(DEC_PT_NUM)) u_dec_plane (
    .inBus(inBus),
    .trueMask(cfgDecTrue),
    .compMask(cfgDecComp),
    .ptEnable(cfgDecEn),
    .pt(decPt)
  );

  // standby: idle input bus with turbo off freezes the registered decode and chip select outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevBus_r <= '0;
      idleCnt_r <= 4'h0;
      standby_r <= 1'b0;
    end else begin
      prevBus_r <= inBus;
      if (inBus != prevBus_r || pwr0_r[TURBO_BIT]) begin
        idleCnt_r <= 4'h0;
        standby_r <= 1'b0;
      end else if (idleCnt_r < 4'(STANDBY_CYC)) begin
        idleCnt_r <= idleCnt_r + 4'h1;
      end else begin
        standby_r <= 1'b1;
      end
    end
  end

  // decode selects, registered so pins never glitch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mainSel_r <= 8'h00;
      bootSel_r <= 4'h0;
      sramSel_r <= 1'b0;
      cfgSel_r <= 1'b0;
      jtagSel_r <= 1'b0;
      periphSel_r <= 2'h0;
    end else if (!standby_r) begin
      for (int s = 0; s < 8; s++) begin
        mainSel_r[s] <= |decPt[DEC_MAIN_LSB + s*DEC_TERMS +: DEC_TERMS];
      end
      for (int s = 0; s < 4; s++) begin
        bootSel_r[s] <= |decPt[DEC_BOOT_LSB + s*DEC_TERMS +: DEC_TERMS];
      end
      sramSel_r <= |decPt[DEC_SRAM_LSB +: DEC_TERMS];
      cfgSel_r <= decPt[DEC_CFG];
      jtagSel_r <= decPt[DEC_JTAG];
      periphSel_r <= decPt[DEC_PERIPH_LSB +: 2];
    end
  end

  // external chip selects: one term each, no cell consumed
  genvar e;
  generate
    for (e = 0; e < ECS_NUM; e++) begin : g_ecs
      assign ecsVal[e] = ptPick(genPt, cfgEcsSel[e*PT_IDX_W +: PT_IDX_W]) ^ cfgEcsPol[e];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ecsC_r <= 8'h00;
      ecsF_r <= 8'h00;
    end else if (!standby_r) begin
      ecsC_r <= ecsVal & ~cfgEcsToPortF;
      ecsF_r <= ecsVal & cfgEcsToPortF;
    end
  end

  // clock sources; logic clock input is already synchronous
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      logicClkPrev_r <= 1'b0;
      ptClkPrev_r <= '0;
    end else begin
      logicClkPrev_r <= logicClockIn;
      ptClkPrev_r <= cellPtClk;
    end
  end
  assign logicClkRise = logicClockIn & ~logicClkPrev_r;

  // host load: byte lanes follow the host's endianness
  assign cellWrite = regWr && (regAddr == REG_CELLS);
  assign loadWord = bigEndianHost ? {regWdata[7:0], regWdata[15:8]} : regWdata;

  // output cells
  genvar c;
  genvar s;
  generate
    for (c = 0; c < CELL_NUM; c++) begin : g_cell
      logic [SLOT_NUM-1:0] slotHit;
      logic sum;
      logic clr;
      logic pre;
      logic clkEv;
      logic loadEn;
      logic maskBit;
      for (s = 0; s < SLOT_NUM; s++) begin : g_slot
        if (s < cellLimit(c)) begin : g_live
          assign slotHit[s] = cfgSlotEn[c*SLOT_NUM + s]
                              & ptPick(genPt, cfgSlotSel[(c*SLOT_NUM + s)*PT_IDX_W +: PT_IDX_W]);
        end else begin : g_dead
          assign slotHit[s] = 1'b0;
        end
      end
      assign sum = |slotHit;
      assign pre = cfgPresetUse[c] & ptPick(genPt, cfgPresetSel[c*PT_IDX_W +: PT_IDX_W]);
      assign clr = (cfgClr0Use[c] & ptPick(genPt, cfgClr0Sel[c*PT_IDX_W +: PT_IDX_W]))
                   | (cfgClr1Use[c] & ptPick(genPt, cfgClr1Sel[c*PT_IDX_W +: PT_IDX_W]));
      assign cellPtClk[c] = ptPick(genPt, cfgClkSel[c*PT_IDX_W +: PT_IDX_W]);
      assign clkEv = cfgClkFromPin[c] ? logicClkRise : (cellPtClk[c] & ~ptClkPrev_r[c]);
      assign maskBit = (c < 8) ? maskA_r[c % 8] : maskB_r[c % 8];
      assign loadEn = cellWrite & ~maskBit;

      pla_out_cell u_cell (
        .ref_clk(ref_clk),
        .rst(rst),
        .sumIn(sum),
        .auxIn(ptPick(genPt, cfgAuxSel[c*PT_IDX_W +: PT_IDX_W])),
        .presetIn(pre),
        .clearIn(clr),
        .clkEvent(clkEv),
        .loadEn(loadEn),
        .loadBit(loadWord[c]),
        .ffType(pla_ff_e'(cfgFfType[c*2 +: 2])),
        .polarity(cfgPolarity[c]),
        .regOut(cfgRegOut[c]),
        .cellOut(cellOut[c]),
        .cellQ(cellQ[c])
      );
    end
  endgenerate

  // feedback is sampled once per clock; a combinational cell fed by itself
  // would otherwise form a loop the tools cannot time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fbA_r <= 8'h00;
      fbB_r <= 8'h00;
    end else begin
      fbA_r <= cellOut[7:0];
      fbB_r <= cellOut[15:8];
    end
  end

  assign portAOut = fbA_r;
  assign portBOut = fbB_r;

  // software registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      maskA_r <= MASK_RST;
      maskB_r <= MASK_RST;
    end else if (regWr && regAddr == REG_MASK_A) begin
      maskA_r <= regWdata[7:0];
    end else if (regWr && regAddr == REG_MASK_B) begin
      maskB_r <= regWdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr0_r <= PWR0_RST;
      pwr2_r <= PWR2_RST;
      page_r <= PAGE_RST;
    end else if (regWr) begin
      if (regAddr == REG_PWR0) begin
        pwr0_r <= regWdata[7:0];
      end
      if (regAddr == REG_PWR2) begin
        pwr2_r <= regWdata[PWR2_W-1:0];
      end
      if (regAddr == REG_PAGE) begin
        page_r <= regWdata[7:0];
      end
    end
  end

  // readback: cell flip-flops, same lane order as loading
  assign cellWordOrdered = bigEndianHost ? {cellQ[7:0], cellQ[15:8]} : cellQ;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (regRd) begin
      unique case (regAddr)
        REG_CELLS: rdata_r <= cellWordOrdered;
        REG_MASK_A: rdata_r <= {8'h00, maskA_r};
        REG_MASK_B: rdata_r <= {8'h00, maskB_r};
        REG_IN_AB: rdata_r <= {portBIn, portAIn};
        REG_IN_C: rdata_r <= {8'h00, portCIn};
        REG_PWR0: rdata_r <= {8'h00, pwr0_r};
        REG_PWR2: rdata_r <= {11'h000, pwr2_r};
        REG_PAGE: rdata_r <= {8'h00, page_r};
        REG_STATUS: rdata_r <= {14'h0000, flashReadyIn, standby_r};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign regRdata = rdata_r;
  assign mainSectorSel = mainSel_r;
  assign bootSectorSel = bootSel_r;
  assign sramSel = sramSel_r;
  assign configSpaceSel = cfgSel_r;
  assign jtagSel = jtagSel_r;
  assign periphSel = periphSel_r;
  assign ecsPortC = ecsC_r;
  assign ecsPortF = ecsF_r;
  assign arrayStandby = standby_r;

endmodule : pla_logic_top
`default_nettype wire

// file: pla_logic_asserts.sv
// Purpose: port-level checks of the programmable logic section
// Assumes: one ref_clk domain, synchronous active-high rst
// Notes: mask state is internal, so cell loads are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module pla_logic_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host port
  input wire logic [3:0] regAddr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  // pins and modes
  input wire logic [19:0] addrIn,
  input wire logic flashReadyIn,
  input wire logic sepSpaceMode,
  input wire logic [pla_pkg::ECS_NUM-1:0] cfgEcsToPortF,
  // outputs
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] ecsPortC,
  input wire logic [7:0] ecsPortF,
  input wire logic [7:0] mainSectorSel,
  input wire logic [3:0] bootSectorSel,
  input wire logic arrayStandby
);
  import pla_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rd_at(logic [3:0] a);
    regRd && regAddr == a;
  endsequence
  sequence rd_unmapped;
    regRd && regAddr > REG_STATUS;
  endsequence
  rdata_idle_a: assert property (!regRd |=> regRdata == 16'h0000) else $error("read data outside slot");
  unmapped_zero_a: assert property (rd_unmapped |=> regRdata == 16'h0000) else $error("unmapped read not zero");
  status_ready_a: assert property (rd_at(REG_STATUS) |=> regRdata[15:1] == {14'h0000, $past(flashReadyIn)})
    else $error("status ready bit wrong");
  pwr2_width_a: assert property (rd_at(REG_PWR2) |=> regRdata[15:5] == 11'h000) else $error("power bits too wide");
  reset_clear_a: assert property ($fell(rst) |-> {portAOut, portBOut, ecsPortC, ecsPortF, mainSectorSel} == 40'h0
    && !arrayStandby) else $error("outputs not clear after reset");
  ecs_route_a: assert property ((ecsPortF & ~cfgEcsToPortF) == 8'h00 && (ecsPortC & cfgEcsToPortF) == 8'h00)
    else $error("chip select on wrong port");
  standby_wake_a: assert property ($changed(sepSpaceMode ? addrIn[19:4] : addrIn[15:0]) |=> !arrayStandby)
    else $error("standby kept after input change");
  standby_hold_a: assert property (arrayStandby |=> $stable(mainSectorSel) && $stable(bootSectorSel)
    && $stable(ecsPortC)) else $error("selects moved in standby");
  standby_seen_c: cover property (arrayStandby);
endmodule : pla_logic_asserts
bind pla_logic_top pla_logic_asserts pla_logic_asserts_i (.*);
`default_nettype wire

// file: pla_host_model.sv
// Purpose: host controller on the register strobe port
// Assumes: strobes one cycle, read data one cycle after the strobe
// Notes: address and data inverted when idle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module pla_host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [3:0] regAddr,
  output logic [15:0] regWdata,
  output logic regWr,
  output logic regRd,
  input wire logic [15:0] regRdata
);
  initial begin
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    @(posedge ref_clk);
    d = regRdata;
  endtask : rd
endmodule : pla_host_model
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench of the programmable logic section
// Assumes: cells on the logic clock pin, D type first pass, T type second, few terms on
// Notes: run twice, second pass in separate space and swapped byte mode
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pla_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic regWr, regRd;
  logic [19:0] addrIn = 20'h0;
  logic [2:0] busCtlIn = 3'h0;
  logic rstPinIn = 1'b0, powerDownIn = 1'b0, flashReadyIn = 1'b1, logicClockIn = 1'b0;
  logic [7:0] portAIn = 8'h0, portBIn = 8'h0, portCIn = 8'h0, portFIn = 8'h0;
  logic [3:0] portDIn = 4'h0;
  logic sepSpaceMode = 1'b0, bigEndianHost = 1'b0;
  logic [GEN_PT_NUM*IN_BUS_W-1:0] cfgGenTrue, cfgGenComp;
  logic [GEN_PT_NUM-1:0] cfgGenEn;
  logic [DEC_PT_NUM*IN_BUS_W-1:0] cfgDecTrue, cfgDecComp;
  logic [DEC_PT_NUM-1:0] cfgDecEn;
  logic [CELL_NUM*SLOT_NUM*PT_IDX_W-1:0] cfgSlotSel;
  logic [CELL_NUM*SLOT_NUM-1:0] cfgSlotEn;
  logic [CELL_NUM*PT_IDX_W-1:0] cfgAuxSel, cfgPresetSel, cfgClr0Sel, cfgClr1Sel, cfgClkSel;
  logic [CELL_NUM-1:0] cfgPresetUse, cfgClr0Use, cfgClr1Use, cfgClkFromPin, cfgPolarity, cfgRegOut;
  logic [CELL_NUM*2-1:0] cfgFfType;
  logic [ECS_NUM*PT_IDX_W-1:0] cfgEcsSel;
  logic [ECS_NUM-1:0] cfgEcsPol, cfgEcsToPortF;
  logic [7:0] portAOut, portBOut, ecsPortC, ecsPortF, mainSectorSel;
  logic [3:0] bootSectorSel;
  logic [1:0] periphSel;
  logic sramSel, configSpaceSel, jtagSel, arrayStandby;
  logic [15:0] d, m, rd, cells, a;
  int cycles = 0, mismatches = 0, nCompared = 0;
  pla_logic_top pla_logic_top_i (.*);
  pla_host_model pla_host_model_i (.*);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // host byte order against cell order
  function automatic logic [15:0] swap(input logic [15:0] w);
    return bigEndianHost ? {w[7:0], w[15:8]} : w;
  endfunction : swap
  task automatic pins;
    {portAIn, portBIn, portCIn, portFIn} <= 32'($urandom());
    {portDIn, busCtlIn, rstPinIn, powerDownIn} <= 9'($urandom());
  endtask : pins
  task automatic pulse;
    @(posedge ref_clk);
    logicClockIn <= 1'b1;
    @(posedge ref_clk);
    logicClockIn <= 1'b0;
  endtask : pulse
  task automatic run_all(input logic sep, input logic big);
    logic [3:0] rAddr [6];
    logic [15:0] rVal [6];
    rAddr = '{REG_MASK_A, REG_MASK_B, REG_PWR0, REG_PWR2, REG_PAGE, 4'hf};
    rVal = '{{8'h0, MASK_RST}, {8'h0, MASK_RST}, {8'h0, PWR0_RST}, {11'h0, PWR2_RST}, {8'h0, PAGE_RST}, 16'h0};
    rst <= 1'b1;
    sepSpaceMode <= sep;
    bigEndianHost <= big;
    // storage type changes only under reset, so it stays static while running
    cfgFfType <= big ? {CELL_NUM{2'(FF_T)}} : {CELL_NUM{2'(FF_D)}};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    cells = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      pla_host_model_i.rd(rAddr[i], rd);
      check(rd, rVal[i]);
    end
    pla_host_model_i.rd(REG_STATUS, rd);
    check(rd, {14'h0, flashReadyIn, 1'b0});
    d = 16'($urandom());
    pla_host_model_i.wr(REG_PWR2, d);
    pla_host_model_i.wr(REG_PAGE, ~d);
    pla_host_model_i.rd(REG_PWR2, rd);
    check(rd, {11'h0, d[4:0]});
    pla_host_model_i.rd(REG_PAGE, rd);
    check(rd, {8'h0, ~d[7:0]});
    // masked loads, first round unmasked
    for (int i = 0; i < 8; i++) begin
      m = 16'($urandom()) & {16{i > 0}};
      d = 16'($urandom());
      pins();
      pla_host_model_i.wr(REG_MASK_A, {8'h0, m[7:0]});
      pla_host_model_i.wr(REG_MASK_B, {8'h0, m[15:8]});
      pla_host_model_i.wr(REG_CELLS, d);
      cells = (cells & m) | (swap(d) & ~m);
      pla_host_model_i.rd(REG_CELLS, rd);
      check(rd, swap(cells));
      check({portBOut, portAOut}, cells);
      pla_host_model_i.rd(REG_IN_AB, rd);
      check(rd, {portBIn, portAIn});
    end
    pla_host_model_i.wr(REG_MASK_A, 16'h0);
    pla_host_model_i.wr(REG_MASK_B, 16'h0);
    pulse();
    // d type takes the polarity bit, t type toggles where it is set
    cells = big ? (cells ^ cfgPolarity) : cfgPolarity;
    pla_host_model_i.rd(REG_CELLS, rd);
    check(rd, swap(cells));
    d = 16'($urandom());
    // load and clock edge in the same cycle, load must win
    fork
      pla_host_model_i.wr(REG_CELLS, d);
      pulse();
    join
    pla_host_model_i.rd(REG_CELLS, rd);
    check(rd, d);
    pla_host_model_i.wr(REG_PWR0, 16'h0);
    repeat (4) @(posedge ref_clk);
    check({15'h0, arrayStandby}, 16'h1);
    pla_host_model_i.rd(REG_STATUS, rd);
    check(rd, {14'h0, flashReadyIn, 1'b1});
    addrIn <= addrIn ^ 20'h10;
    repeat (2) @(posedge ref_clk);
    check({15'h0, arrayStandby}, 16'h0);
    pla_host_model_i.wr(REG_PWR0, {8'h0, PWR0_RST});
    for (int i = 0; i < 8; i++) begin
      addrIn <= 20'($urandom());
      // one extra edge: standby may still freeze the selects on the first edge
      repeat (3) @(posedge ref_clk);
      a = sep ? addrIn[19:4] : addrIn[15:0];
      check({8'h0, mainSectorSel}, {15'h0, a[15]});
      check({12'h0, bootSectorSel}, {15'h0, ~a[15]});
      check({11'h0, sramSel, configSpaceSel, jtagSel, periphSel}, {13'h0, a[14], 2'h0});
      check({ecsPortF, ecsPortC}, {7'h0, a[0], {7{a[0]}}, 1'b0});
    end
  endtask : run_all
  initial begin
    void'($urandom(32'h5a55));
    {cfgGenTrue, cfgGenComp, cfgGenEn, cfgDecTrue, cfgDecComp, cfgDecEn} = '0;
    {cfgSlotSel, cfgSlotEn, cfgAuxSel, cfgPresetSel, cfgClr0Sel, cfgClr1Sel, cfgClkSel} = '0;
    {cfgPresetUse, cfgClr0Use, cfgClr1Use, cfgFfType, cfgEcsSel, cfgEcsPol} = '0;
    cfgClkFromPin = '1;
    cfgRegOut = '1;
    cfgPolarity = 16'($urandom());
    cfgEcsToPortF = 8'h01;
    cfgGenEn[0] = 1'b1;
    cfgGenTrue[BUS_ADDR_LSB] = 1'b1;
    cfgDecEn[DEC_MAIN_LSB] = 1'b1;
    cfgDecTrue[BUS_ADDR_LSB + 15] = 1'b1;
    cfgDecEn[DEC_BOOT_LSB] = 1'b1;
    cfgDecComp[DEC_BOOT_LSB * IN_BUS_W + BUS_ADDR_LSB + 15] = 1'b1;
    cfgDecEn[DEC_JTAG] = 1'b1;
    cfgDecTrue[DEC_JTAG * IN_BUS_W + BUS_ADDR_LSB + 14] = 1'b1;
    run_all(1'b0, 1'b0);
    run_all(1'b1, 1'b1);
    complete_run();
  end
endmodule : tb
`default_nettype wire
